/* fcit_pkg.sv */
// constants and types shared by the instruction sequencer and its decoder
// assumes one system clock; program memory answers a fetch within the same machine cycle
package fcit_pkg;

  localparam int unsigned CLK_PER_MC = 4;
  localparam logic [1:0] PHASE_FETCH = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] PC_STEP = 8'h01;

  // status word bit positions
  localparam int unsigned PSW_CY = 7;
  localparam int unsigned PSW_AC = 6;
  localparam int unsigned PSW_OV = 2;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [15:0] PC_RST = 16'h0000;

  // opcodes with their own timing or flag effect
  localparam logic [7:0] OP_AJMP_LOW = 8'h01;
  localparam logic [7:0] OP_ACALL_LOW = 8'h11;
  localparam logic [7:0] OP_CJNE_DIR = 8'hB5;
  localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DEC_PTR = 8'hA5;
  localparam logic [7:0] OP_DA = 8'hD4;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_SETB_C = 8'hD3;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_ANL_C = 8'h82;
  localparam logic [7:0] OP_ANL_NC = 8'hB0;
  localparam logic [7:0] OP_ORL_C = 8'h72;
  localparam logic [7:0] OP_ORL_NC = 8'hA0;
  localparam logic [7:0] OP_MOV_C = 8'hA2;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
  localparam logic [2:0] DIVMUL_CYCLES = 3'h5;
  localparam logic [2:0] DEC_PTR_CYCLES = 3'h2;

  typedef enum logic [4:0] {
    FC_NONE, FC_ADD, FC_ADDC, FC_SUBB, FC_MUL, FC_DIV, FC_DA, FC_RRC, FC_RLC,
    FC_CLR, FC_SET, FC_CPL, FC_ANL, FC_ANLN, FC_ORL, FC_ORLN, FC_MOV, FC_CJNE
  } fcit_flag_e;

endpackage : fcit_pkg

/* fcit_dec_if.sv */
// carries one opcode to the decoder and its timing and flag class back
// assumes the decoder is purely combinational
`timescale 1ns/1ps
interface fcit_dec_if;
  logic [7:0] opcode;
  logic [1:0] bytes;
  logic [2:0] cycles;
  logic is_abs;
  logic branch;
  logic [4:0] flag_cls;

  modport dec (input opcode, output bytes, output cycles, output is_abs, output branch, output flag_cls);
  modport seq (output opcode, input bytes, input cycles, input is_abs, input branch, input flag_cls);
endinterface : fcit_dec_if

/* fcit_decode.sv */
// opcode to length, machine cycle count and flag class
// assumes the opcode is stable while the sequencer looks at the answer
`timescale 1ns/1ps
module fcit_decode (
  fcit_dec_if.dec d
);

  logic [7:0] op;
  fcit_pkg::fcit_flag_e cls;

  assign op = d.opcode;

  always_comb begin
    d.is_abs = (op[3:0] == fcit_pkg::OP_AJMP_LOW[3:0]);
    // byte length
    if (d.is_abs) begin
      d.bytes = 2'h2;
    end else if (op == 8'h02 || op == 8'h12 || op == 8'h10 || op == 8'h20 || op == 8'h30 ||
                 op == 8'h43 || op == fcit_pkg::OP_ANL_DIR_IMM || op == 8'h63 || op == 8'h75 ||
                 op == 8'h85 || op == 8'h90 || op[7:4] == 4'hB && op[3:2] != 2'h0 ||
                 op == 8'hB4 || op == fcit_pkg::OP_DJNZ_DIR) begin
      d.bytes = 2'h3;
    end else if (op == 8'h40 || op == 8'h50 || op == 8'h60 || op == 8'h70 || op == 8'h80 ||
                 op == 8'h05 || op == 8'h15 || op[7:4] >= 4'h2 && op[7:4] <= 4'h6 && op[3:1] == 3'h2 ||
                 op == 8'h74 || op == 8'h94 || op == 8'h95 || op == 8'h42 || op == 8'h52 ||
                 op == 8'h62 || op == 8'h72 || op == 8'h82 || op == 8'h92 || op == 8'hA0 ||
                 op == 8'hA2 || op == 8'hB0 || op == 8'hB2 || op == 8'hC2 || op == 8'hD2 ||
                 op == 8'h86 || op == 8'h87 || op[7:3] == 5'h11 || op == 8'h76 || op == 8'h77 ||
                 op[7:3] == 5'h0F || op == 8'hA6 || op == 8'hA7 || op[7:3] == 5'h15 ||
                 op == 8'hC0 || op == 8'hD0 || op == 8'hC5 || op == 8'hE5 || op == 8'hF5 ||
                 op[7:3] == 5'h1B) begin
      d.bytes = 2'h2;
    end else begin
      d.bytes = 2'h1;
    end
    // jumps and calls need one more cycle to form the target
    d.branch = d.is_abs || op == 8'h02 || op == 8'h12 || op == 8'h22 || op == 8'h32 ||
               op == 8'h73 || op[7:4] <= 4'h8 && op[3:0] == 4'h0 && op != 8'h00 ||
               op[7:4] == 4'hB && op[3:2] != 2'h0 || op == 8'hB4 ||
               op == fcit_pkg::OP_DJNZ_DIR || op[7:3] == 5'h1B;
    if (op == fcit_pkg::OP_DIV || op == fcit_pkg::OP_MUL) begin
      d.cycles = fcit_pkg::DIVMUL_CYCLES;
    end else if (op == fcit_pkg::OP_DEC_PTR) begin
      d.cycles = fcit_pkg::DEC_PTR_CYCLES;
    end else begin
      d.cycles = {1'b0, d.bytes} + {2'h0, d.branch};
    end
    // flag class
    if (op[7:4] == 4'h2 && op[3:0] >= 4'h4) begin
      cls = fcit_pkg::FC_ADD;
    end else if (op[7:4] == 4'h3 && op[3:0] >= 4'h4) begin
      cls = fcit_pkg::FC_ADDC;
    end else if (op[7:4] == 4'h9 && op[3:0] >= 4'h4) begin
      cls = fcit_pkg::FC_SUBB;
    end else if (op == fcit_pkg::OP_MUL) begin
      cls = fcit_pkg::FC_MUL;
    end else if (op == fcit_pkg::OP_DIV) begin
      cls = fcit_pkg::FC_DIV;
    end else if (op == fcit_pkg::OP_DA) begin
      cls = fcit_pkg::FC_DA;
    end else if (op == fcit_pkg::OP_RRC) begin
      cls = fcit_pkg::FC_RRC;
    end else if (op == fcit_pkg::OP_RLC) begin
      cls = fcit_pkg::FC_RLC;
    end else if (op == fcit_pkg::OP_CLR_C) begin
      cls = fcit_pkg::FC_CLR;
    end else if (op == fcit_pkg::OP_SETB_C) begin
      cls = fcit_pkg::FC_SET;
    end else if (op == fcit_pkg::OP_CPL_C) begin
      cls = fcit_pkg::FC_CPL;
    end else if (op == fcit_pkg::OP_ANL_C) begin
      cls = fcit_pkg::FC_ANL;
    end else if (op == fcit_pkg::OP_ANL_NC) begin
      cls = fcit_pkg::FC_ANLN;
    end else if (op == fcit_pkg::OP_ORL_C) begin
      cls = fcit_pkg::FC_ORL;
    end else if (op == fcit_pkg::OP_ORL_NC) begin
      cls = fcit_pkg::FC_ORLN;
    end else if (op == fcit_pkg::OP_MOV_C) begin
      cls = fcit_pkg::FC_MOV;
    end else if (op[7:4] == 4'hB && op[3:2] != 2'h0) begin
      cls = fcit_pkg::FC_CJNE;
    end else begin
      cls = fcit_pkg::FC_NONE;
    end
    d.flag_cls = cls;
  end

endmodule : fcit_decode

/* fcit_core.sv */
// instruction fetch sequencer and flag unit of the four-clock core
// assumes program memory presents the fetched byte on fetch_data_i by the last clock of the machine cycle
// and that the execute path presents its operands on the last clock of the instruction
`timescale 1ns/1ps
module fcit_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // program memory
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o,
  input wire logic [7:0] fetch_data_i,
  // execute operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] b_i,
  input wire logic bit_i,
  input wire logic take_i,
  input wire logic [15:0] target_i,
  input wire logic psw_wr_i,
  input wire logic [7:0] psw_wdata_i,
  // status
  output logic cy_o,
  output logic ac_o,
  output logic ov_o,
  output logic [7:0] opcode_o,
  output logic instr_done_o,
  output logic [4:0] instr_clocks_o
);

  fcit_dec_if dif ();

  fcit_decode u_decode (
    .d(dif.dec)
  );

  logic [1:0] phase, next_phase;
  logic [2:0] mc_cnt, next_mc_cnt;
  logic [15:0] pc, next_pc;
  logic [7:0] opcode, next_opcode;
  logic [7:0] operand1, next_operand1;
  logic cy, next_cy;
  logic ac, next_ac;
  logic ov, next_ov;
  logic done, next_done;
  logic [4:0] clocks, next_clocks;
  logic fetch_cycle;
  logic last_clk;
  logic instr_end;
  logic [8:0] sum;
  logic sum_c3;
  logic sum_c6;
  logic [15:0] prod;
  logic [8:0] da_val;
  fcit_pkg::fcit_flag_e cls;

  // eight-bit add with carry in; subtraction uses the inverted operand and borrow
  // result is {carry out of bit 3, carry out of bit 6, nine-bit sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [7:0] mid;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {lo[4], mid[7], full};
  endfunction : add8

  assign dif.opcode = (mc_cnt == 3'h0) ? fetch_data_i : opcode;
  assign cls = fcit_pkg::fcit_flag_e'(dif.flag_cls);
  assign last_clk = (phase == fcit_pkg::PHASE_LAST);
  // the opcode cycle always fetches; later cycles fetch only while bytes remain
  assign fetch_cycle = (mc_cnt == 3'h0) || (mc_cnt < {1'b0, dif.bytes});
  assign instr_end = last_clk && (mc_cnt + 3'h1 == dif.cycles);

  // arithmetic for the flag unit
  always_comb begin
    logic [10:0] r;
    r = 11'h000;
    if (cls == fcit_pkg::FC_SUBB) begin
      r = add8(acc_i, ~src_i, ~cy);
    end else begin
      r = add8(acc_i, src_i, (cls == fcit_pkg::FC_ADDC) ? cy : 1'b0);
    end
    sum = r[8:0];
    sum_c6 = r[9];
    sum_c3 = r[10];
    prod = {8'h00, acc_i} * {8'h00, b_i};
    da_val = {1'b0, acc_i};
    if (acc_i[3:0] > 4'h9 || ac) begin
      da_val = da_val + 9'h006;
    end
    if (da_val[7:4] > 4'h9 || cy || da_val[8]) begin
      da_val = da_val + 9'h060;
    end
  end

  // machine cycle sequencing
  always_comb begin
    next_phase = phase + 2'h1;
    next_mc_cnt = mc_cnt;
    next_pc = pc;
    next_opcode = opcode;
    next_operand1 = operand1;
    next_done = 1'b0;
    next_clocks = clocks;
    if (last_clk) begin
      if (fetch_cycle) begin
        next_pc = pc + {8'h00, fcit_pkg::PC_STEP};
        if (mc_cnt == 3'h0) begin
          next_opcode = fetch_data_i;
        end else if (mc_cnt == 3'h1) begin
          next_operand1 = fetch_data_i;
        end
      end else if (dif.branch && mc_cnt + 3'h1 == dif.cycles) begin
        // destination formed in the extra cycle, before the next opcode fetch
        if (dif.is_abs) begin
          next_pc = {pc[15:11], opcode[7:5], operand1};
        end else if (take_i) begin
          next_pc = target_i;
        end
      end
      if (instr_end) begin
        next_mc_cnt = 3'h0;
        next_done = 1'b1;
        next_clocks = 5'(dif.cycles * fcit_pkg::CLK_PER_MC);
      end else begin
        next_mc_cnt = mc_cnt + 3'h1;
      end
    end
  end

  // flag effects, applied when the instruction retires
  always_comb begin
    next_cy = cy;
    next_ac = ac;
    next_ov = ov;
    if (instr_end) begin
      case (cls)
        fcit_pkg::FC_ADD, fcit_pkg::FC_ADDC: begin
          next_cy = sum[8];
          next_ac = sum_c3;
          next_ov = sum[8] ^ sum_c6;
        end
        fcit_pkg::FC_SUBB: begin
          // inverted operand: borrow is the missing carry
          next_cy = ~sum[8];
          next_ac = ~sum_c3;
          next_ov = sum[8] ^ sum_c6;
        end
        fcit_pkg::FC_MUL: begin
          next_cy = 1'b0;
          next_ov = (prod[15:8] != 8'h00);
        end
        fcit_pkg::FC_DIV: begin
          next_cy = 1'b0;
          next_ov = (b_i == 8'h00);
        end
        fcit_pkg::FC_DA: next_cy = cy | da_val[8];
        fcit_pkg::FC_RRC: next_cy = acc_i[0];
        fcit_pkg::FC_RLC: next_cy = acc_i[7];
        fcit_pkg::FC_CLR: next_cy = 1'b0;
        fcit_pkg::FC_SET: next_cy = 1'b1;
        fcit_pkg::FC_CPL: next_cy = ~cy;
        fcit_pkg::FC_ANL: next_cy = cy & bit_i;
        fcit_pkg::FC_ANLN: next_cy = cy & ~bit_i;
        fcit_pkg::FC_ORL: next_cy = cy | bit_i;
        fcit_pkg::FC_ORLN: next_cy = cy | ~bit_i;
        fcit_pkg::FC_MOV: next_cy = bit_i;
        fcit_pkg::FC_CJNE: next_cy = (acc_i < src_i);
        default: begin
          // direct status word writes are the only other source
          if (psw_wr_i) begin
            next_cy = psw_wdata_i[fcit_pkg::PSW_CY];
            next_ac = psw_wdata_i[fcit_pkg::PSW_AC];
            next_ov = psw_wdata_i[fcit_pkg::PSW_OV];
          end
        end
      endcase
    end else if (psw_wr_i) begin
      next_cy = psw_wdata_i[fcit_pkg::PSW_CY];
      next_ac = psw_wdata_i[fcit_pkg::PSW_AC];
      next_ov = psw_wdata_i[fcit_pkg::PSW_OV];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= fcit_pkg::PHASE_FETCH;
      mc_cnt <= 3'h0;
      pc <= fcit_pkg::PC_RST;
      opcode <= 8'h00;
      operand1 <= 8'h00;
      cy <= fcit_pkg::FLAGS_RST[2];
      ac <= fcit_pkg::FLAGS_RST[1];
      ov <= fcit_pkg::FLAGS_RST[0];
      done <= 1'b0;
      clocks <= 5'h00;
    end else begin
      phase <= next_phase;
      mc_cnt <= next_mc_cnt;
      pc <= next_pc;
      opcode <= next_opcode;
      operand1 <= next_operand1;
      cy <= next_cy;
      ac <= next_ac;
      ov <= next_ov;
      done <= next_done;
      clocks <= next_clocks;
    end
  end

  // one request, in the first clock of a fetching machine cycle only
  assign fetch_req_o = (phase == fcit_pkg::PHASE_FETCH) && fetch_cycle;
  assign fetch_addr_o = pc;
  assign cy_o = cy;
  assign ac_o = ac;
  assign ov_o = ov;
  assign opcode_o = opcode;
  assign instr_done_o = done;
  assign instr_clocks_o = clocks;

endmodule : fcit_core

/* fcit_core_sva.sv */
// assertions on the ports of the four-clock instruction sequencer
// assumes one clock domain; reset is asynchronous and active low
`timescale 1ns/1ps
module fcit_core_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // watched signals
  input wire logic fetch_req_o,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] src_i,
  input wire logic psw_wr_i,
  input wire logic cy_o,
  input wire logic ac_o,
  input wire logic ov_o,
  input wire logic [7:0] opcode_o,
  input wire logic instr_done_o,
  input wire logic [4:0] instr_clocks_o
);
  logic [4:0] n_clk;
  logic [2:0] n_fetch;
  logic [8:0] add_sum;
  assign add_sum = {1'b0, acc_i} + {1'b0, src_i};
  // clocks and fetches since the current instruction began
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_clk <= 5'h00;
      n_fetch <= 3'h0;
    end else begin
      n_clk <= instr_done_o ? 5'h01 : n_clk + 5'h01;
      n_fetch <= (instr_done_o ? 3'h0 : n_fetch) + {2'h0, fetch_req_o};
    end
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_fetch_mc;
    fetch_req_o ##1 !fetch_req_o [*3];
  endsequence
  sequence s_retire;
    instr_done_o ##1 !instr_done_o [*3];
  endsequence
  a_fetch_gap: assert property (fetch_req_o |-> s_fetch_mc)
    else $error("two fetches inside one machine cycle");
  a_clock_count: assert property (instr_done_o |-> instr_clocks_o == n_clk && instr_clocks_o[1:0] == 2'h0)
    else $error("reported clocks differ from elapsed clocks");
  a_done_gap: assert property (instr_done_o |-> s_retire)
    else $error("instructions retire closer than four clocks");
  a_no_idle: assert property (instr_done_o |-> fetch_req_o && n_fetch != 3'h0
    && {n_fetch, 2'h0} <= instr_clocks_o)
    else $error("idle or dummy cycle around an instruction");
  a_abs_extra: assert property (instr_done_o && opcode_o[3:0] == 4'h1
    |-> instr_clocks_o == 5'h0C && n_fetch == 3'h2 && !$past(fetch_req_o, 4))
    else $error("absolute jump or call timing wrong");
  a_cmp_branch: assert property (instr_done_o && opcode_o == 8'hB5
    |-> instr_clocks_o == 5'h10 && n_fetch == 3'h3)
    else $error("compare and branch timing wrong");
  a_and_imm: assert property (instr_done_o && opcode_o == 8'h53
    |-> instr_clocks_o == 5'h0C && n_fetch == 3'h3)
    else $error("and immediate into direct timing wrong");
  a_muldiv_flags: assert property (instr_done_o && (opcode_o == 8'hA4 || opcode_o == 8'h84)
    |-> !cy_o && $stable(ac_o) && instr_clocks_o == 5'h14)
    else $error("multiply or divide flags wrong");
  a_add_carry: assert property (instr_done_o && opcode_o[7:4] == 4'h2 && opcode_o[3:0] > 4'h3
    |-> cy_o == $past(add_sum[8]))
    else $error("add carry wrong");
  a_carry_fixed: assert property (instr_done_o && (opcode_o == 8'hC3 || opcode_o == 8'hD3)
    |-> cy_o == opcode_o[4])
    else $error("clear or set carry wrong");
  a_cmp_carry: assert property (instr_done_o && opcode_o == 8'hB5 |-> cy_o == $past(acc_i < src_i))
    else $error("compare carry wrong");
  a_carry_only: assert property (instr_done_o && opcode_o inside {8'h13, 8'h33, 8'hB3, 8'hD4, 8'hA2}
    |-> $stable({ac_o, ov_o}))
    else $error("carry-only operation touched other flags");
  a_flag_hold: assert property ($changed({cy_o, ac_o, ov_o}) |-> instr_done_o || $past(psw_wr_i))
    else $error("flags changed outside retire or status write");
endmodule : fcit_core_sva

bind fcit_core fcit_core_sva u_sva (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .fetch_req_o(fetch_req_o),
  .acc_i(acc_i), .src_i(src_i), .psw_wr_i(psw_wr_i), .cy_o(cy_o), .ac_o(ac_o), .ov_o(ov_o),
  .opcode_o(opcode_o), .instr_done_o(instr_done_o), .instr_clocks_o(instr_clocks_o));

/* fcit_pmem.sv */
// program memory model: one byte per fetch, handed out in fetch order
// assumes the core samples the byte three edges after its fetch strobe
`timescale 1ns/1ps
module fcit_pmem (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // fetch side
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  output logic [7:0] fetch_data_o
);
  logic [7:0] mem_q[$];
  logic [15:0] aq[$];
  logic [1:0] hold = 2'h0;
  initial fetch_data_o = 8'h00;
  always @(posedge clk_sys_i) begin
    if (rstn_i && fetch_req_i) begin
      aq.push_back(fetch_addr_i);
      fetch_data_o <= (mem_q.size() != 0) ? mem_q.pop_front() : 8'h00;
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
      // data is only promised up to the sampling edge, so spoil it after
      if (hold == 2'h1) fetch_data_o <= ~fetch_data_o;
    end
  end
endmodule : fcit_pmem

/* tb.sv */
// self-checking bench for the four-clock instruction sequencer
// assumes the memory model hands out bytes in fetch order and logs addresses
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fetch_req_o, cy_o, ac_o, ov_o, instr_done_o;
  logic [15:0] fetch_addr_o;
  logic [7:0] fetch_data_i, opcode_o;
  logic [4:0] instr_clocks_o;
  logic [7:0] acc_i = 8'h00, src_i = 8'h00, b_i = 8'h00, psw_wdata_i = 8'h00;
  logic bit_i = 1'b0, take_i = 1'b0, psw_wr_i = 1'b0;
  logic [15:0] target_i = 16'h0000;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cy = 0, ac = 0, ov = 0;
  logic [7:0] prog[$], opnd[$];
  logic [15:0] exp_addr[$];

  always #2.5 clk_sys_i = ~clk_sys_i;

  fcit_core dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .fetch_req_o(fetch_req_o),
    .fetch_addr_o(fetch_addr_o), .fetch_data_i(fetch_data_i), .acc_i(acc_i), .src_i(src_i),
    .b_i(b_i), .bit_i(bit_i), .take_i(take_i), .target_i(target_i), .psw_wr_i(psw_wr_i),
    .psw_wdata_i(psw_wdata_i), .cy_o(cy_o), .ac_o(ac_o), .ov_o(ov_o), .opcode_o(opcode_o),
    .instr_done_o(instr_done_o), .instr_clocks_o(instr_clocks_o));
  fcit_pmem pm (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .fetch_req_i(fetch_req_o),
    .fetch_addr_i(fetch_addr_o), .fetch_data_o(fetch_data_i));

  task automatic chk_bit(input logic got, input int exp);
    cmp_count++;
    if (got !== exp[0]) begin
      n_mismatch++;
      $display("[FAIL] %0t flag got %b exp %0d", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_num(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_num

  // upper nibble bytes, lower nibble machine cycles
  function automatic logic [7:0] op_len(input logic [7:0] op);
    case (op)
      8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: return 8'h22;
      8'h53: return 8'h33;
      8'hB4, 8'hB5, 8'hB8, 8'hD5: return 8'h34;
      8'hD8: return 8'h23;
      8'hA4, 8'h84: return 8'h15;
      8'hA5: return 8'h12;
      default: return (op[3:0] == 4'h1) ? 8'h23 : 8'h11;
    endcase
  endfunction : op_len

  task automatic model(input logic [7:0] op, input int a, input int s, input int b, input int t);
    int c, r;
    c = (op[7:4] == 4'h2) ? 0 : cy;
    r = a;
    if (op[3:0] > 4'h3 && (op[7:4] == 4'h2 || op[7:4] == 4'h3)) begin
      ac = a % 16 + s % 16 + c > 15;
      ov = (a % 128 + s % 128 + c > 127) != (a + s + c > 255);
      cy = a + s + c > 255;
    end
    if (op[3:0] > 4'h3 && op[7:4] == 4'h9) begin
      ac = a % 16 < s % 16 + c;
      ov = (a % 128 < s % 128 + c) != (a < s + c);
      cy = a < s + c;
    end
    case (op)
      8'hA4: ov = a * b > 255;
      8'h84: ov = b == 0;
      8'hD4: begin
        if (r % 16 > 9 || ac) r = r + 6;
        if (r / 16 > 9 || cy) r = r + 96;
        cy = cy || r > 255;
      end
      8'h13: cy = a % 2;
      8'h33: cy = a / 128;
      8'hC3: cy = 0;
      8'hD3: cy = 1;
      8'hB3: cy = !cy;
      8'h82: cy = cy && t;
      8'hB0: cy = cy && !t;
      8'h72: cy = cy || t;
      8'hA0: cy = cy || !t;
      8'hA2: cy = t;
      8'hB4, 8'hB5, 8'hB8: cy = a < s;
      default: ;
    endcase
    if (op == 8'hA4 || op == 8'h84) cy = 0;
  endtask : model

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    int j, k, a, s, bb, lc;
    logic [7:0] op;
    logic [15:0] pc;
    logic [7:0] list[$];
    list = '{8'h28, 8'h2F, 8'h26, 8'h24, 8'h25, 8'h38, 8'h34, 8'h35, 8'h98, 8'h94, 8'hA4, 8'h84,
      8'hD4, 8'h13, 8'h33, 8'hC3, 8'hD3, 8'hB3, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'hB4, 8'hB5,
      8'hB8, 8'h53, 8'hA5, 8'hD8, 8'hD5, 8'h04, 8'h14, 8'hE4, 8'h00};
    void'($urandom(12671));
    for (k = 0; k < 8; k++) begin
      list.push_back(8'(k * 32 + 1));
      list.push_back(8'(k * 32 + 17));
    end
    // whole program is loaded before reset lets the first fetch go
    for (j = 0; j < 3 * list.size(); j++) begin
      op = list[j % list.size()];
      lc = op_len(op);
      prog.push_back(op);
      pm.mem_q.push_back(op);
      opnd.push_back(8'($urandom));
      for (k = 1; k < lc / 16; k++) pm.mem_q.push_back(k == 1 ? opnd[j] : 8'($urandom));
    end
    pc = 16'h0000;
    repeat (12) @(posedge clk_sys_i);
    for (j = 0; j < prog.size(); j++) begin
      op = prog[j];
      lc = op_len(op);
      a = $urandom % 256;
      s = $urandom % 256;
      // first pass divides by zero on purpose
      bb = (j < list.size()) ? 0 : $urandom % 256;
      acc_i <= 8'(a);
      src_i <= 8'(s);
      b_i <= 8'(bb);
      bit_i <= 1'($urandom);
      take_i <= 1'($urandom);
      target_i <= 16'($urandom);
      rstn_i <= 1'b1;
      if (op == 8'hE4) begin
        psw_wdata_i <= 8'($urandom);
        psw_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        psw_wr_i <= 1'b0;
        cy = psw_wdata_i[7];
        ac = psw_wdata_i[6];
        ov = psw_wdata_i[2];
      end
      k = 0;
      do begin
        @(posedge clk_sys_i);
        k++;
      end while (instr_done_o !== 1'b1 && k < 30);
      if (k >= 30) begin
        n_mismatch++;
        $display("[FAIL] %0t no completion", $time);
        break;
      end
      model(op, a, s, bb, int'(bit_i));
      chk_bit(cy_o, cy);
      chk_bit(ac_o, ac);
      chk_bit(ov_o, ov);
      chk_num(16'(instr_clocks_o), 16'(lc % 16 * 4));
      chk_num(16'(opcode_o), 16'(op));
      for (k = 0; k < lc / 16; k++) exp_addr.push_back(pc + 16'(k));
      pc = pc + 16'(lc / 16);
      if (op[3:0] == 4'h1) pc = {pc[15:11], op[7:5], opnd[j]};
      if (op inside {8'hB4, 8'hB5, 8'hB8, 8'hD5, 8'hD8} && take_i) pc = target_i;
    end
    for (k = 0; k < exp_addr.size(); k++) chk_num(pm.aq[k], exp_addr[k]);
    stop_test();
  end
endmodule : tb
